// ### core/fcset_slave.sv
// Serial memory slave engine: samples on clock rise, drives on clock fall.
`timescale 1ns/10ps
module fcset_slave (
    // Clock and reset.
    input  wire logic                               clk,
    input  wire logic                               rst,
    // Serial pins from the host, asynchronous to clk.
    input  wire fcset_pkg::fcset_pins_t             pins,
    // Serial data output pin and its enable.
    output logic                                    so,
    output logic                                    so_oe,
    // Received byte strobe.
    output logic                                    rx_valid,
    output logic [fcset_pkg::FCSET_BYTE_W-1:0]      rx_data,
    // Bytes queued for sending to the host.
    input  wire logic                               tx_valid,
    output logic                                    tx_ready,
    input  wire logic [fcset_pkg::FCSET_BYTE_W-1:0] tx_data,
    // Status.
    output logic                                    frame_active,
    output logic                                    tx_underrun
);
    import fcset_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    fcset_pins_t            sync1_reg;        // First synchroniser stage.
    fcset_pins_t            sync2_reg;        // Second synchroniser stage.
    fcset_pins_t            prev_reg;         // Delayed copy for edge detection.
    fcset_state_t           state_reg;        // Frame state.
    fcset_state_t           state_next;       // Next frame state.
    logic [FCSET_CNT_W-1:0] rx_cnt_reg;       // Bits received in the current byte.
    logic [FCSET_CNT_W-1:0] rx_cnt_next;      // Next receive count.
    logic [FCSET_CNT_W-1:0] tx_cnt_reg;       // Bits sent in the current byte.
    logic [FCSET_CNT_W-1:0] tx_cnt_next;      // Next send count.
    logic [7:0]             rx_shift_reg;     // Receive shift register.
    logic [7:0]             rx_shift_next;    // Next receive shift value.
    logic [7:0]             tx_shift_reg;     // Bits still to send.
    logic [7:0]             tx_shift_next;    // Next send shift value.
    logic [7:0]             rx_data_reg;      // Last complete received byte.
    logic [7:0]             rx_data_next;     // Next received byte.
    logic                   rx_valid_reg;     // Byte strobe.
    logic                   rx_valid_next;    // Next byte strobe.
    logic                   so_reg;           // Serial output level.
    logic                   so_next;          // Next serial output level.
    logic                   so_oe_reg;        // Serial output enable.
    logic                   so_oe_next;       // Next serial output enable.
    logic                   underrun_reg;     // Fill byte sent strobe.
    logic                   underrun_next;    // Next fill strobe.
    logic                   frame_reg;        // Frame state as a registered flag.
    logic                   frame_next;       // Next frame flag.
    logic                   cs_act;           // Chip select seen asserted.
    logic                   sck_rise;         // Rising serial clock edge.
    logic                   sck_fall;         // Falling serial clock edge.
    logic                   fifo_valid;       // Queued byte available.
    logic                   fifo_pop;         // Take the queued byte.
    logic [7:0]             fifo_data;        // Oldest queued byte.
    logic [7:0]             load_byte;        // Byte starting on this falling edge.

    // Every output is taken straight from a register, so the pins and the
    // user logic never see a decode glitch between clock edges.
    assign so           = so_reg;
    assign so_oe        = so_oe_reg;
    assign rx_valid     = rx_valid_reg;
    assign rx_data      = rx_data_reg;
    assign frame_active = frame_reg;
    assign tx_underrun  = underrun_reg;

    // ------------------------------------------------------------------
    // Transmit buffer
    // ------------------------------------------------------------------
    // The engine pops only at byte boundaries, so a slow host lets the
    // buffer fill and tx_ready drops until the host clocks bytes out.
    fcset_fifo #(
        .WIDTH (FCSET_BYTE_W),
        .DEPTH (FCSET_FIFO_DEPTH)
    ) u_tx_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (tx_valid),
        .in_ready  (tx_ready),
        .in_data   (tx_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_data)
    );

    // ------------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------------
    // Only the second stage and its delayed copy feed any logic, so a
    // metastable first stage never reaches an edge detector.
    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_reg <= FCSET_PINS_RST;
            sync2_reg <= FCSET_PINS_RST;
            prev_reg  <= FCSET_PINS_RST;
        end else begin
            sync1_reg <= pins;
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
        end
    end

    // All three pins travel through the same stages, so data and select
    // stay aligned with the clock edges that the detectors report.
    assign cs_act   = !sync2_reg.cs_n;
    assign sck_rise = sync2_reg.sck && !prev_reg.sck;
    assign sck_fall = !sync2_reg.sck && prev_reg.sck;

    // ------------------------------------------------------------------
    // Serial engine next-state logic
    // ------------------------------------------------------------------
    // The SCK edges are recovered by oversampling, so the host clock must
    // stay well below clk; the pin-to-output latency is three clk cycles.
    always_comb begin
        state_next    = state_reg;
        rx_cnt_next   = rx_cnt_reg;
        tx_cnt_next   = tx_cnt_reg;
        rx_shift_next = rx_shift_reg;
        tx_shift_next = tx_shift_reg;
        rx_data_next  = rx_data_reg;
        rx_valid_next = 1'b0;
        so_next       = so_reg;
        so_oe_next    = so_oe_reg;
        underrun_next = 1'b0;
        fifo_pop      = 1'b0;
        load_byte     = fifo_valid ? fifo_data : FCSET_FILL;
        // The defaults above hold every register but the rx_valid_next and underrun_next strobes, which clear, so a cycle without a
        // serial clock edge leaves the shift state untouched.
        unique case (state_reg)
            FCSET_IDLE: begin
                // A new frame always starts on a byte boundary.
                rx_cnt_next = FCSET_CNT_RST;
                tx_cnt_next = FCSET_CNT_RST;
                so_next     = FCSET_SO_IDLE;
                so_oe_next  = 1'b0;
                if (cs_act) begin
                    state_next = FCSET_FRAME;
                    so_oe_next = 1'b1;
                end
            end
            FCSET_FRAME: begin
                if (!cs_act) begin
                    // Releasing select abandons any partial byte.
                    state_next = FCSET_IDLE;
                    so_oe_next = 1'b0;
                    so_next    = FCSET_SO_IDLE;
                end else begin
                    if (sck_rise) begin
                        // Sample host data on the rising edge, MSB first.
                        rx_shift_next = {rx_shift_reg[6:0], sync2_reg.si};
                        rx_cnt_next   = rx_cnt_reg + FCSET_CNT_STEP;
                        if (rx_cnt_reg == FCSET_CNT_LAST) begin
                            rx_data_next  = {rx_shift_reg[6:0], sync2_reg.si};
                            rx_valid_next = 1'b1;
                        end
                    end
                    if (sck_fall) begin
                        // Launch the next output bit on the falling edge.
                        tx_cnt_next = tx_cnt_reg + FCSET_CNT_STEP;
                        if (tx_cnt_reg == FCSET_CNT_RST) begin
                            fifo_pop      = fifo_valid;
                            underrun_next = !fifo_valid;
                            so_next       = load_byte[FCSET_MSB];
                            tx_shift_next = {load_byte[6:0], 1'b0};
                        end else begin
                            so_next       = tx_shift_reg[FCSET_MSB];
                            tx_shift_next = {tx_shift_reg[6:0], 1'b0};
                        end
                    end
                end
            end
        endcase
        // The status flag follows the next state, so it moves with state_reg.
        frame_next    = (state_next == FCSET_FRAME);
    end

    // ------------------------------------------------------------------
    // Serial engine registers
    // ------------------------------------------------------------------
    // Reset drops any frame in progress; a select still held low reopens the frame
    // once it has passed the synchroniser, which restarts from a released select.
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg    <= FCSET_IDLE;
            frame_reg    <= 1'b0;
            rx_cnt_reg   <= FCSET_CNT_RST;
            tx_cnt_reg   <= FCSET_CNT_RST;
            rx_shift_reg <= FCSET_BYTE_RST;
            tx_shift_reg <= FCSET_BYTE_RST;
            rx_data_reg  <= FCSET_BYTE_RST;
            rx_valid_reg <= 1'b0;
            so_reg       <= FCSET_SO_IDLE;
            so_oe_reg    <= 1'b0;
            underrun_reg <= 1'b0;
        end else begin
            state_reg    <= state_next;
            frame_reg    <= frame_next;
            rx_cnt_reg   <= rx_cnt_next;
            tx_cnt_reg   <= tx_cnt_next;
            rx_shift_reg <= rx_shift_next;
            tx_shift_reg <= tx_shift_next;
            rx_data_reg  <= rx_data_next;
            rx_valid_reg <= rx_valid_next;
            so_reg       <= so_next;
            so_oe_reg    <= so_oe_next;
            underrun_reg <= underrun_next;
        end
    end

endmodule

// ### core/fcset_pkg.sv
// Package of constants and types shared by the full-cycle serial edge timing block.
package fcset_pkg;

    // ------------------------------------------------------------------
    // Serial word layout
    // ------------------------------------------------------------------
    localparam int          FCSET_BYTE_W   = 8;          // Bits in one serial byte.
    localparam int          FCSET_CNT_W    = 3;          // Width of the bit counters.
    localparam logic [2:0]  FCSET_CNT_RST  = 3'h0;       // Bit counter value at byte start.
    localparam logic [2:0]  FCSET_CNT_LAST = 3'h7;       // Bit counter value of the last bit.
    localparam logic [2:0]  FCSET_CNT_STEP = 3'h1;       // Bit counter increment.
    localparam int          FCSET_MSB      = 7;          // Position of the first bit sent.

    // ------------------------------------------------------------------
    // Reset values and fill data
    // ------------------------------------------------------------------
    localparam logic [7:0]  FCSET_BYTE_RST = 8'h00;      // Shift and data registers at reset.
    localparam logic [7:0]  FCSET_FILL     = 8'hff;      // Byte sent when no data is queued.
    localparam logic        FCSET_SO_IDLE  = 1'b1;       // Serial output level while idle.

    // ------------------------------------------------------------------
    // Transmit buffer shape
    // ------------------------------------------------------------------
    localparam int          FCSET_FIFO_DEPTH = 8;        // Words held in the transmit FIFO.

    // ------------------------------------------------------------------
    // Pin bundle carried through the synchroniser
    // ------------------------------------------------------------------
    typedef struct packed {
        logic sck;                                       // Serial clock from the host.
        logic cs_n;                                      // Chip select, active low.
        logic si;                                        // Serial data from the host.
    } fcset_pins_t;

    localparam fcset_pins_t FCSET_PINS_RST = '{sck: 1'b0, cs_n: 1'b1, si: 1'b0};

    // ------------------------------------------------------------------
    // Frame state
    // ------------------------------------------------------------------
    typedef enum logic {
        FCSET_IDLE,                                      // Chip select released.
        FCSET_FRAME                                      // Chip select asserted.
    } fcset_state_t;

endpackage

// ### core/fcset_fifo.sv
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/10ps
module fcset_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset.
    input  wire logic             clk,
    input  wire logic             rst,
    // Filling side.
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Draining side.
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    // ------------------------------------------------------------------
    // Storage and pointers
    // ------------------------------------------------------------------
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];   // Word storage in flip-flops.
    logic [WIDTH-1:0] mem_next [DEPTH];  // Next contents of the storage.
    logic [PTR_W-1:0] wr_ptr_reg;        // Slot for the next written word.
    logic [PTR_W-1:0] wr_ptr_next;       // Next write slot.
    logic [PTR_W-1:0] rd_ptr_reg;        // Slot of the oldest word.
    logic [PTR_W-1:0] rd_ptr_next;       // Next read slot.
    logic [CNT_W-1:0] count_reg;         // Words held.
    logic [CNT_W-1:0] count_next;        // Next word count.
    logic             in_ready_reg;      // Registered room flag.
    logic             in_ready_next;     // Next room flag.
    logic             out_valid_reg;     // Registered data flag.
    logic             out_valid_next;    // Next data flag.
    logic             push;              // Word accepted this cycle.
    logic             pop;               // Word removed this cycle.

    assign in_ready  = in_ready_reg;
    assign out_valid = out_valid_reg;
    assign out_data  = mem_reg[rd_ptr_reg];

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    // The flags are registered from the next count, so a full FIFO refuses a
    // push even if a pop happens in the same cycle; this costs one cycle of
    // throughput at the full mark but keeps both flags glitch free.
    always_comb begin
        push        = in_valid && in_ready_reg;
        pop         = out_valid_reg && out_ready;
        mem_next    = mem_reg;
        wr_ptr_next = wr_ptr_reg;
        rd_ptr_next = rd_ptr_reg;
        count_next  = count_reg;
        if (push) begin
            mem_next[wr_ptr_reg] = in_data;
            wr_ptr_next = (wr_ptr_reg == PTR_LAST) ? '0 : wr_ptr_reg + PTR_W'(1);
        end
        if (pop) begin
            rd_ptr_next = (rd_ptr_reg == PTR_LAST) ? '0 : rd_ptr_reg + PTR_W'(1);
        end
        if (push && !pop) begin
            count_next = count_reg + CNT_W'(1);
        end else if (pop && !push) begin
            count_next = count_reg - CNT_W'(1);
        end
        in_ready_next  = (count_next != CNT_FULL);
        out_valid_next = (count_next != '0);
    end

    // ------------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr_reg    <= '0;
            rd_ptr_reg    <= '0;
            count_reg     <= '0;
            in_ready_reg  <= 1'b1;
            out_valid_reg <= 1'b0;
            for (int i = 0; i < DEPTH; i++) begin
                mem_reg[i] <= '0;
            end
        end else begin
            mem_reg       <= mem_next;
            wr_ptr_reg    <= wr_ptr_next;
            rd_ptr_reg    <= rd_ptr_next;
            count_reg     <= count_next;
            in_ready_reg  <= in_ready_next;
            out_valid_reg <= out_valid_next;
        end
    end

endmodule

// ### bench/fcset_slave_asserts.sv
// Concurrent checks on the ports of the serial slave engine, bound into it.
`timescale 1ns/10ps
module fcset_slave_asserts (
    // Clock and reset.
    input wire logic                               clk,
    input wire logic                               rst,
    // Serial side.
    input wire fcset_pkg::fcset_pins_t             pins,
    input wire logic                               so,
    input wire logic                               so_oe,
    // User side.
    input wire logic                               rx_valid,
    input wire logic [fcset_pkg::FCSET_BYTE_W-1:0] rx_data,
    input wire logic                               tx_valid,
    input wire logic                               tx_ready,
    input wire logic                               frame_active,
    input wire logic                               tx_underrun
);
    import fcset_pkg::*;

    // ------------------------------------------------------------------
    // Edge history of the serial clock pin
    // ------------------------------------------------------------------
    logic       sck_reg,  sck_next;   // Clock pin level at the last sample.
    logic [4:0] fall_reg, fall_next;  // Recent falls, newest in bit 0.
    logic [4:0] rise_reg, rise_next;  // Recent rises, newest in bit 0.

    // The slave needs two to four samples to react, so five samples of history
    // cover its latency while an sck period of eight or more cycles stays distinct.
    always_comb begin
        sck_next  = pins.sck;
        fall_next = {fall_reg[3:0], sck_reg & ~pins.sck};
        rise_next = {rise_reg[3:0], ~sck_reg & pins.sck};
    end

    always_ff @(posedge clk) begin
        sck_reg  <= sck_next;
        fall_reg <= fall_next;
        rise_reg <= rise_next;
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    so_on_fall_a: assert property (so_oe && $past(so_oe) && $changed(so) |-> |fall_reg)
        else $error("serial output moved without a clock fall");
    so_idle_a: assert property (!so_oe |-> so)
        else $error("serial output not high while idle");
    rx_on_rise_a: assert property (rx_valid |-> |rise_reg)
        else $error("byte received without a clock rise");
    rx_pulse_a: assert property (rx_valid |=> !rx_valid)
        else $error("receive strobe longer than one cycle");
    load_on_fall_a: assert property (tx_underrun |-> !$past(tx_underrun) && |fall_reg)
        else $error("underrun not tied to a byte load");
    frame_open_a: assert property ($fell(pins.cs_n) |-> !frame_active ##[1:3] frame_active)
        else $error("frame did not open after select");
    frame_close_a: assert property ($rose(pins.cs_n) |->
        ##[1:4] (!so_oe && !frame_active && so))
        else $error("frame did not close after deselect");
    idle_quiet_a: assert property (pins.cs_n [*5] |-> !rx_valid && !tx_underrun)
        else $error("activity while not selected");
    rx_hold_a: assert property (!rx_valid |-> $stable(rx_data))
        else $error("received byte changed without strobe");
    fifo_fill_a: assert property ($fell(tx_ready) |-> $past(tx_valid))
        else $error("buffer filled without a push");

    cover property (rx_valid);
    cover property (tx_underrun);
    cover property ($rose(pins.cs_n) ##3 !so_oe);
endmodule

bind fcset_slave fcset_slave_asserts u_asserts (
    .clk(clk), .rst(rst), .pins(pins), .so(so), .so_oe(so_oe), .rx_valid(rx_valid),
    .rx_data(rx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .frame_active(frame_active), .tx_underrun(tx_underrun)
);

// ### bench/fcset_host_model.sv
// Host model that drives the serial pins in full-cycle or half-cycle timing.
`timescale 1ns/10ps
module fcset_host_model (
    // Clock the model paces itself by.
    input  wire logic              clk,
    // Serial pins towards the slave and its data output.
    output fcset_pkg::fcset_pins_t pins,
    input  wire logic              so
);
    import fcset_pkg::*;

    initial pins = FCSET_PINS_RST;

    // Outside a frame the data line toggles so nothing leans on a stale bit.
    always @(negedge clk) begin
        if (pins.cs_n) begin
            pins.si <= ~pins.si;
        end
    end

    // Select, then leave the slave time to open the frame before any clock edge.
    task automatic select();
        pins.cs_n = 1'b0;
        repeat (4) @(negedge clk);
    endtask

    // Release the select and hold it high long enough for the slave to close.
    task automatic deselect();
        repeat (2) @(negedge clk);
        pins.cs_n = 1'b1;
        repeat (8) @(negedge clk);
    endtask

    // Exchange nb bits MSB first; h is the half period in cycles, at least 5,
    // which keeps the serial clock far below both frequency ceilings.
    task automatic xfer(input logic [7:0] mo, input int nb, input int h, input bit full,
                        output logic [7:0] mi);
        mi = 8'h00;
        pins.si = mo[7];
        repeat (h) @(negedge clk);
        for (int i = 0; i < nb; i++) begin
            pins.sck = 1'b1;
            if (!full && i > 0) mi = {mi[6:0], so};
            repeat (2) @(negedge clk);
            if (i < 7) pins.si = mo[6-i];
            repeat (h - 2) @(negedge clk);
            pins.sck = 1'b0;
            if (full && i > 0) mi = {mi[6:0], so};
            repeat (h) @(negedge clk);
        end
        // The last bit is taken a whole or half period after its fall.
        if (full) repeat (h) @(negedge clk);
        mi = {mi[6:0], so};
    endtask
endmodule

// ### bench/tb_full_cycle_serial_edge_timing.sv
// Self-checking bench for the serial slave engine driven by the host model.
`timescale 1ns/10ps
module tb_full_cycle_serial_edge_timing;
    import fcset_pkg::*;

    logic        clk = 1'b0;        // System clock, 40 ns period.
    logic        rst = 1'b1;        // Synchronous reset, held for 20 cycles.
    logic        tx_valid = 1'b0;   // Push request towards the buffer.
    logic [7:0]  tx_data = 8'h00;   // Byte offered to the buffer.
    logic [7:0]  seed = 8'h58;      // Random state, starts at 88.
    logic        so, so_oe, rx_valid, tx_ready, frame_active, tx_underrun;
    logic [7:0]  rx_data;           // Last byte received.
    fcset_pins_t pins;              // Pins from the host model.
    int          errors = 0, check_count = 0, und_exp = 0, und_seen = 0;
    logic [7:0]  rx_q[$], tx_q[$];  // Expected bytes per direction.

    initial forever #20 clk = ~clk;

    fcset_slave dut (.clk(clk), .rst(rst), .pins(pins), .so(so), .so_oe(so_oe),
        .rx_valid(rx_valid), .rx_data(rx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .tx_data(tx_data), .frame_active(frame_active), .tx_underrun(tx_underrun));
    fcset_host_model host (.clk(clk), .pins(pins), .so(so));

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic chk(input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("Error at %0t ns: expected %h got %h", $time, e, g);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Offer a byte; it is noted only if the buffer has room at this edge.
    task automatic push(input logic [7:0] d);
        tx_valid = 1'b1;
        tx_data  = d;
        if (tx_ready === 1'b1) tx_q.push_back(d);
        @(negedge clk);
    endtask

    // One host exchange; an empty buffer means the fill byte and an underrun.
    task automatic xchg(input int nb, input int h, input bit full);
        logic [7:0] mo, e, mi;
        seed = lfsr(seed);
        mo = seed;
        und_exp += int'(tx_q.size() == 0);
        e = (tx_q.size() > 0) ? tx_q.pop_front() : FCSET_FILL;
        if (nb == 8) rx_q.push_back(mo);
        host.xfer(mo, nb, h, full, mi);
        if (nb == 8) chk(e, mi);
    endtask

    // Received bytes are matched with the oldest note when the strobe shows.
    always @(negedge clk) begin
        if (rx_valid === 1'b1) begin
            chk((rx_q.size() > 0) ? rx_q.pop_front() : 8'hxx, rx_data);
        end
        if (tx_underrun === 1'b1) und_seen++;
    end

    // A hang is cut short well past the roughly 1700 cycles the run needs.
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        finish_test();
    end

    initial begin
        repeat (20) @(negedge clk);
        rst = 1'b0;
        repeat (3) @(negedge clk);
        chk(8'h90, {so, so_oe, frame_active, tx_ready, 4'h0});
        chk(8'h00, rx_data);
        $display("test reset done");
        // Nine offers: the ninth meets a full buffer and is dropped.
        for (int i = 0; i < 9; i++) begin
            seed = lfsr(seed);
            push(seed);
        end
        tx_valid = 1'b0;
        chk(8'h00, {7'h00, tx_ready});
        // Drain past empty with a host that alternates fast and slow clocks.
        host.select();
        for (int i = 0; i < 9; i++) xchg(8, 5 + 4 * (i % 2), 1'b1);
        host.deselect();
        chk(8'h01, {7'h00, tx_ready});
        $display("test full cycle done");
        push(8'h3c);
        push(8'hc3);
        tx_valid = 1'b0;
        host.select();
        for (int i = 0; i < 2; i++) xchg(8, 6, 1'b0);
        host.deselect();
        $display("test half cycle done");
        // A partial byte is abandoned and the next frame starts clean.
        host.select();
        xchg(3, 5, 1'b1);
        host.deselect();
        push(8'h81);
        tx_valid = 1'b0;
        host.select();
        xchg(8, 7, 1'b1);
        host.deselect();
        $display("test abandon done");
        // A reset in mid-run empties the buffer.
        push(8'h5a);
        tx_valid = 1'b0;
        rst = 1'b1;
        repeat (3) @(negedge clk);
        rst = 1'b0;
        tx_q.delete();
        repeat (3) @(negedge clk);
        host.select();
        xchg(8, 5, 1'b1);
        host.deselect();
        chk(und_exp[7:0], und_seen[7:0]);
        $display("test second reset done");
        finish_test();
    end
endmodule
